// ### tmcr_consts.vh
// Constants for the TLB and memory-management register block.
// Assumes inclusion by tmcr_unit.v, the checker and the bench; definitions only.
`ifndef TMCR_CONSTS_VH
`define TMCR_CONSTS_VH
// Register numbers of the coprocessor move port
`define TMCR_REG_INDEX 5'h00
`define TMCR_REG_RANDOM 5'h01
`define TMCR_REG_LO0 5'h02
`define TMCR_REG_LO1 5'h03
`define TMCR_REG_PAGEMASK 5'h05
`define TMCR_REG_WIRED 5'h06
`define TMCR_REG_TLB_ENTRY_HIGH_STAGE 5'h0A
`define TMCR_REG_REVID 5'h0F
`define TMCR_REG_CONFIG 5'h10
`define TMCR_REG_LINKED_LOAD_ADDRESS 5'h11
`define TMCR_REG_CACHE_TAG_LOW 5'h1C
`define TMCR_REG_CACHE_TAG_HIGH 5'h1D
// TLB instruction codes
`define TMCR_OP_PROBE 2'h0
`define TMCR_OP_READ 2'h1
`define TMCR_OP_WRITE_IDX 2'h2
`define TMCR_OP_WRITE_RND 2'h3
// Revision identifier fields and wired boundary reset value
`define TMCR_REV_MAJOR 4'h1
`define TMCR_REV_MINOR 4'h0
`define TMCR_WIRED_RESET 6'h00
// Fixed configuration fields
`define TMCR_CFG_L2_BLOCK 2'h1
`define TMCR_CFG_BUS_WIDTH 2'h0
`define TMCR_CFG_ONE 1'h1
`define TMCR_CFG_PARITY_MODE 1'h1
`define TMCR_CFG_SUBBLOCK 1'h1
`define TMCR_CFG_L1_CAP 3'h3
`define TMCR_CFG_LINE_32 1'h1
// Coherency attribute codes
`define TMCR_COH_WT_NOALLOC 3'h0
`define TMCR_COH_WT_ALLOC 3'h1
`define TMCR_COH_UNCACHED 3'h2
`define TMCR_COH_WRITEBACK 3'h3
// Cache tag states
`define TMCR_L1_INVALID 2'h0
`define TMCR_L1_VALID 2'h3
`define TMCR_L2_INVALID 3'h0
`define TMCR_L2_VALID 3'h4
// Strap capture delay, cycles after reset release
`define TMCR_STRAP_WAIT 2'h3
`endif

// ### tmcr_unit.v
// TLB, translation check and memory-management registers of the system control unit.
// Assumes one clock, register moves and TLB operations as one-cycle strobes from the core,
// and reset straps held stable around reset release.
`timescale 1ns/1ps
`default_nettype none
`include "tmcr_consts.vh"

// Summary of operation
// - Reset clears the wired boundary, so no entry is protected.
// - Writing the wired boundary reloads the random index with its upper bound.
// - Random writes never touch entries below the wired boundary unless it is set above the upper bound.
// - Refill, invalid or modify faults capture the page pair; space id is kept as staged.
// - Revision id: revision bits 7:0, implementation 15:8, upper half zero.
// - Revision byte holds major in 7:4 and minor in 3:0.
// - Config straps captured three cycles after reset release are read-only; bit 12 and attribute writable.
// - Clock ratio code n means divide by n plus 2; 7 reserved.
// - Write-back pattern code selects spacing of transmitted doublewords.
// - Secondary size: 00 512K, 01 1M, 10 2M, 11 none.
// - Endian bit reads 0 little, 1 big, as strapped at reset.
// - Primary cache size fields give 2^(12+n) bytes; here 32 KB.
// - Line size bits: 0 is 16 bytes, 1 is 32 bytes; here 32.
// - Writable unmapped segment attribute uses page coherency encoding.
// - Load-linked records physical address 35:4; register also software writable.
// - Index store tag ignores staged parity/ECC and computes its own.
// - Primary tag image: address 35:12, even parity, state 0 invalid, 3 valid.
// - Secondary tag image: address 35:19, state 0 invalid, 4 valid.
// - Lookup compares space id unless global, and page-size-masked page bits.
// - Match returns frame, coherency, dirty, valid; valid not used to match.
// - No match raises miss; dirty or valid denial raises modify or invalid.
// - Coherency codes 0..3 defined, 4..7 reserved.
// - Random upper bound is highest entry number, set at reset.
// - Random decrements per instruction between wired boundary and upper bound.
// - Failed probe sets the index register top bit.
module tmcr_unit #(
    parameter TLB_ENTRIES = 48,
    parameter [7:0] IMPL_CODE = 8'h5A // Arbitrary implementation code
) (
    input wire clk,
    input wire rst_n,
    input wire [4:0] regNum,
    input wire regWrEn,
    input wire [31:0] regWrData,
    input wire regRdEn,
    output reg [31:0] regRdData,
    input wire tlbOpValid,
    input wire [1:0] tlbOp,
    input wire instrRetire,
    input wire lookupValid,
    input wire [39:0] lookupVa,
    input wire lookupStore,
    input wire mode64,
    output reg xlatDone,
    output reg [23:0] xlatFrame,
    output reg [2:0] xlatCoh,
    output reg xlatDirty,
    output reg xlatValid,
    output reg xlatUncached,
    output reg xlatCohReserved,
    output reg excMiss,
    output reg excInvalid,
    output reg excModify,
    input wire llValid,
    input wire [35:0] llPaddr,
    input wire tagStoreValid,
    input wire tagIsL2,
    output reg tagWrStrobe,
    output reg [23:0] tagWrAddr,
    output reg [2:0] tagWrState,
    output reg [7:0] tagWrCheck,
    input wire [2:0] strapSysclkRatio,
    input wire [3:0] strapWbPattern,
    input wire [1:0] strapL2Size,
    input wire strapL2Absent,
    input wire strapBigEndian,
    output wire [2:0] unmappedSegAttr,
    output wire unmappedSegUncached,
    output wire l2Enable,
    output wire bigEndian,
    output wire [5:0] randomIndex
);
    localparam integer UPPER_FULL = TLB_ENTRIES - 1;
    localparam [5:0] UPPER = UPPER_FULL[5:0];

    // Page-masked compare of page pair, extension and space id
    function tlbMatch;
        input [26:0] eVpn;
        input [11:0] eMask;
        input eGlob;
        input [7:0] eAsid;
        input [26:0] kVpn;
        input [7:0] kAsid;
        input kMode64;
        begin
            tlbMatch = ((eVpn[18:12] == kVpn[18:12])
                && (((eVpn[11:0] ^ kVpn[11:0]) & ~eMask) == 12'h000)
                && (!kMode64 || (eVpn[26:19] == kVpn[26:19]))
                && (eGlob || (eAsid == kAsid)));
        end
    endfunction

    // Select the odd-page address bit: the highest masked bit, or bit 12 with no mask
    function oddPage;
        input [11:0] mask;
        input [24:12] va;
        integer i;
        begin
            oddPage = va[12];
            for (i = 0; i < 12; i = i + 1)
            begin
                if (mask[i])
                begin
                    oddPage = va[13 + i];
                end
            end
        end
    endfunction

    // TLB storage, not reset: contents are software's job
    reg [26:0] eVpn [0:TLB_ENTRIES-1];
    reg [11:0] eMask [0:TLB_ENTRIES-1];
    reg eGlob [0:TLB_ENTRIES-1];
    reg [7:0] eAsid [0:TLB_ENTRIES-1];
    reg [29:0] eLo0 [0:TLB_ENTRIES-1];
    reg [29:0] eLo1 [0:TLB_ENTRIES-1];

    // Staging and control registers
    reg [5:0] index_q;
    reg probeFail_q;
    reg [5:0] random_q;
    reg [5:0] wired_q;
    reg [30:0] lo0_q;
    reg [30:0] lo1_q;
    reg [11:0] pageMask_q;
    reg [26:0] hiVpn_q;
    reg [7:0] hiAsid_q;
    reg [31:0] linked_load_address_q;
    reg [31:0] cache_tag_low_q;
    reg [31:0] cache_tag_high_q;
    reg cfgL2En_q;
    reg [2:0] cfgAttr_q;
    reg [10:0] cfgStrap_q;
    reg [1:0] strapCnt_q;
    reg [10:0] strapMeta_q;
    reg [10:0] strapSync_q;

    wire wrHit = regWrEn;
    wire [26:0] lookVpn = lookupVa[39:13];
    wire [TLB_ENTRIES-1:0] probeHitVec;
    wire [TLB_ENTRIES-1:0] lookHitVec;

    // Parallel compare for probe and translation
    genvar g;
    generate
        for (g = 0; g < TLB_ENTRIES; g = g + 1)
        begin : gCmp
            assign probeHitVec[g] = tlbMatch(eVpn[g], eMask[g], eGlob[g], eAsid[g],
                hiVpn_q, hiAsid_q, 1'b1);
            assign lookHitVec[g] = tlbMatch(eVpn[g], eMask[g], eGlob[g], eAsid[g],
                lookVpn, hiAsid_q, mode64);
        end
    endgenerate

    // Encode hit positions; software keeps entries unique
    reg [5:0] probeIdx;
    reg [5:0] lookIdx;
    integer k;
    always @*
    begin
        probeIdx = 6'h00;
        lookIdx = 6'h00;
        for (k = 0; k < TLB_ENTRIES; k = k + 1)
        begin
            if (probeHitVec[k])
            begin
                probeIdx = k[5:0];
            end
            if (lookHitVec[k])
            begin
                lookIdx = k[5:0];
            end
        end
    end

    // Even or odd half of the matched pair, back at register bit positions
    wire lookOdd = oddPage(eMask[lookIdx], lookupVa[24:12]);
    wire [30:0] lookLo = {lookOdd ? eLo1[lookIdx] : eLo0[lookIdx], 1'b0};
    wire lookHit = |lookHitVec;
    // Random writes use the random index, which sits below wired only when wired exceeds the upper bound
    wire tlbWrite = tlbOpValid && (tlbOp == `TMCR_OP_WRITE_IDX || tlbOp == `TMCR_OP_WRITE_RND);
    wire [5:0] wrIdx = (tlbOp == `TMCR_OP_WRITE_RND) ? random_q : index_q;

    // TLB entry writes
    always @(posedge clk)
    begin
        if (tlbWrite)
        begin
            eVpn[wrIdx] <= hiVpn_q;
            eMask[wrIdx] <= pageMask_q;
            eGlob[wrIdx] <= lo0_q[0] & lo1_q[0];
            eAsid[wrIdx] <= hiAsid_q;
            eLo0[wrIdx] <= lo0_q[30:1];
            eLo1[wrIdx] <= lo1_q[30:1];
        end
    end

    // Straps cross in through two flops before capture
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strapMeta_q <= 11'h000;
            strapSync_q <= 11'h000;
        end
        else
        begin
            strapMeta_q <= {strapSysclkRatio, strapWbPattern, strapL2Size, strapL2Absent,
                strapBigEndian};
            strapSync_q <= strapMeta_q;
        end
    end

    // Control registers, translation and tag side effects
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wired_q <= `TMCR_WIRED_RESET;
            random_q <= UPPER;
            index_q <= 6'h00;
            probeFail_q <= 1'b0;
            lo0_q <= 31'h0;
            lo1_q <= 31'h0;
            pageMask_q <= 12'h000;
            hiVpn_q <= 27'h0;
            hiAsid_q <= 8'h00;
            linked_load_address_q <= 32'h0;
            cache_tag_low_q <= 32'h0;
            cache_tag_high_q <= 32'h0;
            cfgL2En_q <= 1'b0;
            cfgAttr_q <= `TMCR_COH_UNCACHED;
            cfgStrap_q <= 11'h000;
            strapCnt_q <= 2'h0;
            regRdData <= 32'h0;
            xlatDone <= 1'b0;
            xlatFrame <= 24'h0;
            xlatCoh <= 3'h0;
            xlatDirty <= 1'b0;
            xlatValid <= 1'b0;
            xlatUncached <= 1'b0;
            xlatCohReserved <= 1'b0;
            excMiss <= 1'b0;
            excInvalid <= 1'b0;
            excModify <= 1'b0;
            tagWrStrobe <= 1'b0;
            tagWrAddr <= 24'h0;
            tagWrState <= 3'h0;
            tagWrCheck <= 8'h00;
        end
        else
        begin
            // Strap capture shortly after release, read-only from then on
            if (strapCnt_q != `TMCR_STRAP_WAIT)
            begin
                strapCnt_q <= strapCnt_q + 2'h1;
                if (strapCnt_q + 2'h1 == `TMCR_STRAP_WAIT)
                begin
                    // Packed as ratio, pattern, secondary size, absent, endian
                    cfgStrap_q <= strapSync_q;
                end
            end

            // Random index walks down, wraps to the top at the wired boundary
            if (wrHit && regNum == `TMCR_REG_WIRED)
            begin
                wired_q <= regWrData[5:0];
                random_q <= UPPER;
            end
            else if (instrRetire)
            begin
                random_q <= (random_q <= wired_q) ? UPPER : random_q - 6'h01;
            end

            // Register moves from software
            if (wrHit)
            begin
                case (regNum)
                    `TMCR_REG_INDEX: index_q <= regWrData[5:0];
                    `TMCR_REG_LO0: lo0_q <= regWrData[30:0];
                    `TMCR_REG_LO1: lo1_q <= regWrData[30:0];
                    `TMCR_REG_PAGEMASK: pageMask_q <= regWrData[24:13];
                    `TMCR_REG_TLB_ENTRY_HIGH_STAGE:
                    begin
                        hiVpn_q <= {8'h00, regWrData[31:13]};
                        hiAsid_q <= regWrData[7:0];
                    end
                    `TMCR_REG_CONFIG:
                    begin
                        cfgL2En_q <= regWrData[12];
                        cfgAttr_q <= regWrData[2:0];
                    end
                    `TMCR_REG_LINKED_LOAD_ADDRESS: linked_load_address_q <= regWrData;
                    `TMCR_REG_CACHE_TAG_LOW: cache_tag_low_q <= regWrData;
                    `TMCR_REG_CACHE_TAG_HIGH: cache_tag_high_q <= regWrData;
                    default: ;
                endcase
            end

            // Load-linked address capture; later in order wins over a move
            if (llValid)
            begin
                linked_load_address_q <= llPaddr[35:4];
            end

            // TLB probe and read
            if (tlbOpValid && tlbOp == `TMCR_OP_PROBE)
            begin
                probeFail_q <= ~(|probeHitVec);
                index_q <= (|probeHitVec) ? probeIdx : index_q;
            end
            else if (tlbOpValid && tlbOp == `TMCR_OP_READ)
            begin
                hiVpn_q <= eVpn[index_q];
                hiAsid_q <= eAsid[index_q];
                pageMask_q <= eMask[index_q];
                lo0_q <= {eLo0[index_q], eGlob[index_q]};
                lo1_q <= {eLo1[index_q], eGlob[index_q]};
            end

            // Translation result and fault decision, one cycle after request
            xlatDone <= lookupValid;
            excMiss <= lookupValid && !lookHit;
            excInvalid <= lookupValid && lookHit && !lookLo[1];
            excModify <= lookupValid && lookHit && lookLo[1] && lookupStore && !lookLo[2];
            if (lookupValid)
            begin
                xlatFrame <= lookLo[29:6];
                xlatCoh <= lookLo[5:3];
                xlatDirty <= lookLo[2];
                xlatValid <= lookLo[1] && lookHit;
                xlatUncached <= (lookLo[5:3] == `TMCR_COH_UNCACHED);
                xlatCohReserved <= lookLo[5];
                if (!lookHit || !lookLo[1] || (lookupStore && !lookLo[2]))
                begin
                    hiVpn_q <= lookVpn;
                end
            end

            // Index store tag: staged check bits are not used
            tagWrStrobe <= tagStoreValid;
            if (tagStoreValid)
            begin
                if (tagIsL2)
                begin
                    tagWrAddr <= {cache_tag_low_q[31:15], 7'h00};
                    tagWrState <= cache_tag_low_q[12:10];
                    tagWrCheck <= {1'b0, cache_tag_low_q[31:25] ^ cache_tag_low_q[24:18] ^
                        {cache_tag_low_q[17:15], cache_tag_low_q[12:10], 1'b0}};
                end
                else
                begin
                    tagWrAddr <= cache_tag_low_q[31:8];
                    tagWrState <= {1'b0, cache_tag_low_q[7:6]};
                    tagWrCheck <= {7'h00, ^cache_tag_low_q[31:6]};
                end
            end

            // Registered read data, reserved bits zero
            if (regRdEn)
            begin
                case (regNum)
                    `TMCR_REG_INDEX: regRdData <= {probeFail_q, 25'h0, index_q};
                    `TMCR_REG_RANDOM: regRdData <= {26'h0, random_q};
                    `TMCR_REG_LO0: regRdData <= {1'b0, lo0_q};
                    `TMCR_REG_LO1: regRdData <= {1'b0, lo1_q};
                    `TMCR_REG_PAGEMASK: regRdData <= {7'h00, pageMask_q, 13'h0000};
                    `TMCR_REG_WIRED: regRdData <= {26'h0, wired_q};
                    `TMCR_REG_TLB_ENTRY_HIGH_STAGE: regRdData <= {hiVpn_q[18:0], 5'h00, hiAsid_q};
                    `TMCR_REG_REVID: regRdData <= {16'h0000, IMPL_CODE,
                        `TMCR_REV_MAJOR, `TMCR_REV_MINOR};
                    `TMCR_REG_CONFIG: regRdData <= {1'b0, cfgStrap_q[10:4],
                        `TMCR_CFG_L2_BLOCK, cfgStrap_q[3:2], `TMCR_CFG_BUS_WIDTH,
                        cfgStrap_q[1], `TMCR_CFG_ONE, cfgStrap_q[0],
                        `TMCR_CFG_PARITY_MODE, `TMCR_CFG_SUBBLOCK, cfgL2En_q,
                        `TMCR_CFG_L1_CAP, `TMCR_CFG_L1_CAP,
                        `TMCR_CFG_LINE_32, `TMCR_CFG_LINE_32, 1'b0, cfgAttr_q};
                    `TMCR_REG_LINKED_LOAD_ADDRESS: regRdData <= linked_load_address_q;
                    `TMCR_REG_CACHE_TAG_LOW: regRdData <= cache_tag_low_q;
                    `TMCR_REG_CACHE_TAG_HIGH: regRdData <= cache_tag_high_q;
                    default: regRdData <= 32'h0;
                endcase
            end
        end
    end

    // Space id is carried in the staging register, so faults keep it as is
    assign unmappedSegAttr = cfgAttr_q;
    assign unmappedSegUncached = (cfgAttr_q == `TMCR_COH_UNCACHED);
    assign l2Enable = cfgL2En_q;
    assign bigEndian = cfgStrap_q[0];
    assign randomIndex = random_q;
endmodule // tmcr_unit
`default_nettype wire

// ### tmcr_unit_chk.sv
// Port-level checker for tmcr_unit: strobe timing, random index and decode relations.
// Assumes it is bound to tmcr_unit and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
`include "tmcr_consts.vh"
module tmcr_unit_chk #(
    parameter TLB_ENTRIES = 48
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [4:0] regNum,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [31:0] regRdData,
    input wire logic instrRetire,
    input wire logic lookupValid,
    input wire logic xlatDone,
    input wire logic [2:0] xlatCoh,
    input wire logic xlatValid,
    input wire logic xlatUncached,
    input wire logic xlatCohReserved,
    input wire logic excMiss,
    input wire logic excInvalid,
    input wire logic excModify,
    input wire logic tagStoreValid,
    input wire logic tagWrStrobe,
    input wire logic [2:0] unmappedSegAttr,
    input wire logic unmappedSegUncached,
    input wire logic [5:0] randomIndex
);
    localparam [5:0] TOP = 6'(TLB_ENTRIES - 1);
    wire logic wiredWr;

    // Wired write seen at the move port; it outranks a retire
    assign wiredWr = regWrEn && (regNum == `TMCR_REG_WIRED);

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Read data must not drift between reads
    a_rdata_hold: assert property (!regRdEn |=> $stable(regRdData))
        else $error("read data changed without a read");
    a_done_timing: assert property (xlatDone == $past(lookupValid))
        else $error("lookup done not one cycle after request");
    a_exc_single: assert property ($onehot0({excMiss, excInvalid, excModify}))
        else $error("more than one translation fault");
    a_exc_done: assert property ((excMiss || excInvalid || excModify) |-> xlatDone)
        else $error("fault without lookup done");
    a_fault_unvalid: assert property ((excMiss || excInvalid) |-> !xlatValid)
        else $error("valid translation with miss or invalid fault");
    a_tag_strobe: assert property (tagWrStrobe == $past(tagStoreValid))
        else $error("tag write strobe not one cycle after store");
    a_wired_reload: assert property (wiredWr |=> randomIndex == TOP)
        else $error("wired write did not reload random index");
    a_random_step: assert property (instrRetire && !wiredWr |=>
        (randomIndex == $past(randomIndex) - 6'h01) || (randomIndex == TOP))
        else $error("random index did not step down");
    a_random_hold: assert property (!instrRetire && !wiredWr |=> $stable(randomIndex))
        else $error("random index moved without retire");
    a_seg_uncached: assert property (unmappedSegUncached == (unmappedSegAttr == 3'h2))
        else $error("unmapped segment uncached flag wrong");
    a_xlat_decode: assert property (xlatDone |->
        (xlatUncached == (xlatCoh == 3'h2)) && (xlatCohReserved == xlatCoh[2]))
        else $error("coherency decode wrong");
endmodule // tmcr_unit_chk

bind tmcr_unit tmcr_unit_chk #(.TLB_ENTRIES(TLB_ENTRIES)) uChk (
    .clk(clk), .rst_n(rst_n), .regNum(regNum), .regWrEn(regWrEn), .regRdEn(regRdEn),
    .regRdData(regRdData), .instrRetire(instrRetire), .lookupValid(lookupValid),
    .xlatDone(xlatDone), .xlatCoh(xlatCoh), .xlatValid(xlatValid),
    .xlatUncached(xlatUncached), .xlatCohReserved(xlatCohReserved), .excMiss(excMiss),
    .excInvalid(excInvalid), .excModify(excModify), .tagStoreValid(tagStoreValid),
    .tagWrStrobe(tagWrStrobe), .unmappedSegAttr(unmappedSegAttr),
    .unmappedSegUncached(unmappedSegUncached), .randomIndex(randomIndex)
);
`default_nettype wire

// ### tmcr_unit_tb_top.sv
// Self-checking bench for tmcr_unit: register moves, TLB ops, lookups, tag stores.
// Assumes the constants header and the bound checker; the bench drives every input.
`timescale 1ns/1ps
`default_nettype none
`include "tmcr_consts.vh"
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin errTotal++; \
    $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); end end
module tmcr_unit_tb_top;
    localparam [7:0] IMPL = 8'h3C; // Arbitrary implementation code
    localparam [31:0] CFG = {1'h0, 3'h5, 4'h2, 2'h1, 2'h1, 2'h0, 1'h0, 1'h1, 1'h1, 1'h1,
        1'h1, 1'h0, 3'h3, 3'h3, 1'h1, 1'h1, 1'h0, 3'h0};
    localparam [31:0] EHA = 32'h2468A007;
    localparam [31:0] EHB = 32'h000AA007;
    localparam [39:0] VAA = 40'h002468A000;
    logic clk = 1'h0, rst_n = 1'h0, regWrEn = 1'h0, regRdEn = 1'h0, tlbOpValid = 1'h0;
    logic instrRetire = 1'h0, lookupValid = 1'h0, lookupStore = 1'h0, mode64 = 1'h0;
    logic llValid = 1'h0, tagStoreValid = 1'h0, tagIsL2 = 1'h0;
    logic [4:0] regNum = 5'h00;
    logic [31:0] regWrData = 32'h0;
    logic [1:0] tlbOp = 2'h0;
    logic [39:0] lookupVa = 40'h0;
    logic [35:0] llPaddr = 36'h0;
    logic [2:0] strapSysclkRatio = 3'h5;
    logic [3:0] strapWbPattern = 4'h2;
    logic [1:0] strapL2Size = 2'h1;
    logic strapL2Absent = 1'h0, strapBigEndian = 1'h1;
    wire logic [31:0] regRdData;
    wire logic [23:0] xlatFrame, tagWrAddr;
    wire logic [2:0] xlatCoh, tagWrState, unmappedSegAttr;
    wire logic xlatDone, xlatDirty, xlatValid, xlatUncached, xlatCohReserved, excMiss;
    wire logic excInvalid, excModify, tagWrStrobe, unmappedSegUncached, l2Enable, bigEndian;
    wire logic [7:0] tagWrCheck;
    wire logic [5:0] randomIndex;
    int errTotal = 0, nTests = 0, i;

    tmcr_unit #(.TLB_ENTRIES(48), .IMPL_CODE(IMPL)) dut (
        .clk(clk), .rst_n(rst_n), .regNum(regNum), .regWrEn(regWrEn), .regWrData(regWrData),
        .regRdEn(regRdEn), .regRdData(regRdData), .tlbOpValid(tlbOpValid), .tlbOp(tlbOp),
        .instrRetire(instrRetire), .lookupValid(lookupValid), .lookupVa(lookupVa),
        .lookupStore(lookupStore), .mode64(mode64), .xlatDone(xlatDone), .xlatFrame(xlatFrame),
        .xlatCoh(xlatCoh), .xlatDirty(xlatDirty), .xlatValid(xlatValid),
        .xlatUncached(xlatUncached), .xlatCohReserved(xlatCohReserved), .excMiss(excMiss),
        .excInvalid(excInvalid), .excModify(excModify), .llValid(llValid), .llPaddr(llPaddr),
        .tagStoreValid(tagStoreValid), .tagIsL2(tagIsL2), .tagWrStrobe(tagWrStrobe),
        .tagWrAddr(tagWrAddr), .tagWrState(tagWrState), .tagWrCheck(tagWrCheck),
        .strapSysclkRatio(strapSysclkRatio), .strapWbPattern(strapWbPattern),
        .strapL2Size(strapL2Size), .strapL2Absent(strapL2Absent),
        .strapBigEndian(strapBigEndian), .unmappedSegAttr(unmappedSegAttr),
        .unmappedSegUncached(unmappedSegUncached), .l2Enable(l2Enable),
        .bigEndian(bigEndian), .randomIndex(randomIndex)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    // One-cycle register write strobe
    task wr(input [4:0] n, input [31:0] d);
        @(posedge clk);
        regNum <= n;
        regWrData <= d;
        regWrEn <= 1'h1;
        @(posedge clk);
        regWrEn <= 1'h0;
    endtask

    // Read, then compare under a mask once the registered data settles
    task rdChk(input [4:0] n, input [31:0] e, input [31:0] m = 32'hFFFFFFFF);
        @(posedge clk);
        regNum <= n;
        regRdEn <= 1'h1;
        @(posedge clk);
        regRdEn <= 1'h0;
        @(negedge clk);
        `CHK(regRdData & m, e & m)
    endtask

    task op(input [1:0] o);
        @(posedge clk);
        tlbOp <= o;
        tlbOpValid <= 1'h1;
        @(posedge clk);
        tlbOpValid <= 1'h0;
    endtask

    // Lookup; ex holds expected miss, invalid, modify
    task look(input [39:0] va, input st, input [2:0] ex, input m64 = 1'h0);
        @(posedge clk);
        lookupVa <= va;
        lookupStore <= st;
        mode64 <= m64;
        lookupValid <= 1'h1;
        @(posedge clk);
        lookupValid <= 1'h0;
        @(negedge clk);
        `CHK({xlatDone, excMiss, excInvalid, excModify}, {1'h1, ex})
    endtask

    task tagSt(input l2);
        @(posedge clk);
        tagIsL2 <= l2;
        tagStoreValid <= 1'h1;
        @(posedge clk);
        tagStoreValid <= 1'h0;
        @(negedge clk);
        `CHK(tagWrStrobe, 1'h1)
    endtask

    // Back-to-back retires, n of them
    task retire(input int n);
        @(posedge clk);
        instrRetire <= 1'h1;
        repeat (n) @(posedge clk);
        instrRetire <= 1'h0;
        @(negedge clk);
    endtask

    task conclude;
        $display("Comparisons %0d mismatches %0d", nTests, errTotal);
        if (errTotal == 0 && nTests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Main sequence; straps settle before the first config read
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        rdChk(`TMCR_REG_WIRED, 32'h0);
        rdChk(`TMCR_REG_RANDOM, 32'h2F);
        rdChk(`TMCR_REG_REVID, {16'h0, IMPL, `TMCR_REV_MAJOR, `TMCR_REV_MINOR});
        rdChk(`TMCR_REG_CONFIG, CFG, 32'hFFFFEFF8);
        `CHK(bigEndian, 1'h1)
        wr(`TMCR_REG_CONFIG, 32'hFFFFFFFF);
        rdChk(`TMCR_REG_CONFIG, CFG | 32'h1007);
        `CHK(l2Enable, 1'h1)
        for (i = 0; i < 4; i++)
        begin
            wr(`TMCR_REG_CONFIG, CFG | i);
            @(negedge clk);
            `CHK(unmappedSegAttr, i[2:0])
            `CHK(unmappedSegUncached, i == 2)
        end
        retire(3);
        `CHK(randomIndex, 6'h2C)
        wr(`TMCR_REG_WIRED, 32'hFFFFFFC5);
        @(negedge clk);
        `CHK(randomIndex, 6'h2F)
        rdChk(`TMCR_REG_WIRED, 32'h5);
        retire(42);
        `CHK(randomIndex, 6'h05)
        retire(1);
        `CHK(randomIndex, 6'h2F)
        // Park every entry on a page pair no test address uses; the array has no reset
        for (i = 0; i < 48; i++)
        begin
            wr(`TMCR_REG_INDEX, i);
            wr(`TMCR_REG_TLB_ENTRY_HIGH_STAGE, 32'h80000000 | (i << 13) | 32'hFF);
            op(`TMCR_OP_WRITE_IDX);
        end
        // Entry A at index 10, entry B by random write above the wired boundary
        wr(`TMCR_REG_INDEX, 32'hA);
        wr(`TMCR_REG_TLB_ENTRY_HIGH_STAGE, EHA);
        wr(`TMCR_REG_LO0, 32'h000048D2);
        wr(`TMCR_REG_LO1, 32'h0001159C);
        wr(`TMCR_REG_PAGEMASK, 32'h0);
        op(`TMCR_OP_WRITE_IDX);
        wr(`TMCR_REG_TLB_ENTRY_HIGH_STAGE, EHB);
        op(`TMCR_OP_WRITE_RND);
        op(`TMCR_OP_PROBE);
        rdChk(`TMCR_REG_INDEX, 32'h2F);
        wr(`TMCR_REG_TLB_ENTRY_HIGH_STAGE, EHA ^ 32'h2000);
        op(`TMCR_OP_PROBE);
        rdChk(`TMCR_REG_INDEX, 32'h80000000, 32'h80000000);
        wr(`TMCR_REG_TLB_ENTRY_HIGH_STAGE, EHA);
        op(`TMCR_OP_PROBE);
        rdChk(`TMCR_REG_INDEX, 32'hA);
        op(`TMCR_OP_READ);
        rdChk(`TMCR_REG_LO0, 32'h000048D2);
        look(VAA, 1'h0, 3'h0);
        `CHK(xlatDirty, 1'h0)
        `CHK({xlatFrame, xlatCoh, xlatValid, xlatUncached}, {24'h000123, 3'h2, 2'h3})
        look(VAA, 1'h1, 3'h1);
        look(VAA | 40'h1000, 1'h0, 3'h2);
        look(VAA ^ 40'h2000, 1'h0, 3'h4);
        rdChk(`TMCR_REG_TLB_ENTRY_HIGH_STAGE, EHA ^ 32'h2000);
        look(VAA | 40'h0100000000, 1'h0, 3'h0, 1'h0);
        look(VAA | 40'h0100000000, 1'h0, 3'h4, 1'h1);
        wr(`TMCR_REG_TLB_ENTRY_HIGH_STAGE, EHA + 32'h1);
        look(VAA, 1'h0, 3'h4);
        // Load-linked capture, then software write
        @(posedge clk);
        llPaddr <= 36'hF12345678;
        llValid <= 1'h1;
        @(posedge clk);
        llValid <= 1'h0;
        rdChk(`TMCR_REG_LINKED_LOAD_ADDRESS, 32'hF1234567);
        wr(`TMCR_REG_LINKED_LOAD_ADDRESS, 32'h0BADF00D);
        rdChk(`TMCR_REG_LINKED_LOAD_ADDRESS, 32'h0BADF00D);
        // Staged check bits are junk; the store must recompute them
        wr(`TMCR_REG_CACHE_TAG_LOW, 32'hABCDEFFF);
        tagSt(1'h0);
        `CHK({tagWrAddr, tagWrState}, {24'hABCDEF, 3'h3})
        `CHK(tagWrCheck, {7'h00, ^26'h2AF37BF})
        wr(`TMCR_REG_CACHE_TAG_LOW, {17'h1ABCD, 2'h0, 3'h4, 10'h3FF});
        tagSt(1'h1);
        `CHK({tagWrAddr, tagWrState}, {17'h1ABCD, 7'h00, 3'h4})
        conclude;
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (4000) @(posedge clk);
        errTotal++;
        conclude;
    end
endmodule // tmcr_unit_tb_top
`default_nettype wire
